//--- dv/fca_partner_model.sv
`timescale 1ns/1ns
`default_nettype none
module fca_partner_model
  import fca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire fca_frame_type in_frame,
  input wire fca_enq_type enq,
  input wire logic drain,
  output fca_rel_type rel
);
  fca_rel_type held[$];
  fca_rel_type nxt_rel;
  logic [2:0] iqos_ff;

  // egress queues hold copies until drain lets them go, one per cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel <= '0;
      iqos_ff <= 3'h0;
      held.delete();
    end else begin
      if (in_valid && in_ready) begin
        iqos_ff <= in_frame.qos;
      end
      if (enq.valid === 1'b1) begin
        held.push_back({1'b1, enq.src, enq.port, iqos_ff, enq.qos, enq.words});
      end
      if (drain && held.size() > 0) begin
        rel <= held.pop_front();
      end else begin
        // idle fields show a changing pattern, not the last value
        nxt_rel = ~rel;
        nxt_rel.valid = 1'b0;
        rel <= nxt_rel;
      end
    end
  end
endmodule : fca_partner_model
`default_nettype wire

//--- dv/test_forwarder_congestion_acct.sv
`timescale 1ns/1ns
`default_nettype none
module test_forwarder_congestion_acct;
  import fca_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, in_ready, disc_pulse, blocked;
  logic in_valid = 1'b0;
  logic drain = 1'b1;
  fca_frame_type in_frame = '0;
  fca_rel_type rel;
  fca_enq_type enq;
  fca_enq_type got[$];
  int mismatches = 0;
  int num_checks = 0;
  int ndisc = 0;
  int nblk = 0;
  logic [31:0] q;
  logic e;

  fca_forwarder u_fca_forwarder(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_frame(in_frame), .in_ready(in_ready), .rel(rel), .enq(enq), .disc_pulse(disc_pulse), .blocked(blocked));
  fca_partner_model u_fca_partner_model(.pclk(pclk), .presetn(presetn), .in_valid(in_valid), .in_ready(in_ready),
    .in_frame(in_frame), .enq(enq), .drain(drain), .rel(rel));

  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    if (enq.valid === 1'b1) got.push_back(enq);
    if (disc_pulse === 1'b1) ndisc++;
    if (blocked === 1'b1) nblk++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_idle();
    do begin
      @(posedge pclk);
    end while (in_ready !== 1'b1);
    repeat (2) @(posedge pclk);
  endtask : wait_idle

  task automatic put_frame(input logic [5:0] dest, input logic [7:0] cpu_queue_mask, input logic [1:0] probe,
                           input logic la, input logic dok);
    fca_frame_type f;
    f = '0;
    f.src = 3'h1;
    f.dest = dest;
    f.cpu_queue_mask = cpu_queue_mask;
    f.probe = probe;
    f.learn_all = la;
    f.qos = 3'h3;
    f.drop_ok = dok;
    f.words = 6'h03;
    got.delete();
    in_frame <= f;
    in_valid <= 1'b1;
    do begin
      @(posedge pclk);
    end while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask : put_frame

  task automatic chk_e(input int i, input logic [2:0] port, input logic [2:0] qos, input logic sp);
    chk({16'h0, got[i].port, got[i].qos, got[i].super_prio, got[i].src, got[i].words},
        {16'h0, port, qos, sp, 3'h1, 6'h03});
  endtask : chk_e

  function automatic logic [2:0] qport(input int i);
    return (i < 4) ? 3'(6 + i % 2) : 3'(i - 2);
  endfunction : qport

  task automatic t_regs();
    apb(1'b0, OFS_MODE + 12'h01C, 32'h0);
    chk(q, 32'h3D);
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, OFS_THR + 12'(4 * (r * 4 + 3)), 32'h0);
      chk(q, 32'h1740);
    end
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 12'h002, 32'h5);
    chk({31'h0, e}, 32'h1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_dest();
    put_frame(6'h25, 8'h00, 2'h0, 1'b0, 1'b0);
    wait_idle();
    chk(32'(got.size()), 32'h3);
    chk_e(0, 3'h0, 3'h3, 1'b0);
    chk_e(1, 3'h2, 3'h3, 1'b0);
    chk_e(2, 3'h5, 3'h3, 1'b0);
    $display("test dest done");
  endtask : t_dest

  task automatic t_cpu_queue_mask();
    for (int i = 0; i < 8; i++) apb(1'b1, OFS_COPY + 12'(4 * i), 32'({2'(i % 3), 3'(7 - i), qport(i)}));
    apb(1'b1, OFS_CPUDIS, 32'h80);
    put_frame(6'h00, 8'hFF, 2'h0, 1'b0, 1'b0);
    wait_idle();
    chk(32'(got.size()), 32'h7);
    for (int i = 0; i < 7; i++) begin
      chk({28'h0, got[i].port, got[i].super_prio}, {28'h0, qport(i), 1'(i % 3 == 2)});
      if (i % 3 != 2) chk(32'(got[i].qos), (i % 3 == 0) ? 32'h3 : 32'(7 - i));
    end
    apb(1'b1, OFS_CPUDIS, 32'h0);
    $display("test cpu queues done");
  endtask : t_cpu_queue_mask

  task automatic t_indirect();
    for (int p = 1; p < 4; p++) apb(1'b1, OFS_COPY + 12'(4 * (7 + p)), 32'({2'h1, 3'(p), 3'(p)}));
    apb(1'b1, OFS_COPY + 12'h02C, 32'h74);
    apb(1'b1, OFS_LRN, 32'h0D);
    for (int p = 1; p < 4; p++) begin
      put_frame(6'h00, 8'h00, 2'(p), 1'b1, 1'b0);
      wait_idle();
      chk(32'(got.size()), 32'h3);
      chk_e(0, 3'(p), 3'(p), 1'b0);
      chk_e(1, 3'h4, 3'h6, 1'b0);
      chk(32'(got[2].port), 32'h5);
    end
    apb(1'b1, OFS_LRN, 32'h05);
    put_frame(6'h00, 8'h00, 2'h0, 1'b1, 1'b0);
    wait_idle();
    chk(32'(got.size()), 32'h1);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_fwd_dis();
    int n;
    apb(1'b1, OFS_MODE + 12'h008, 32'h3C);
    put_frame(6'h06, 8'h00, 2'h0, 1'b0, 1'b0);
    wait_idle();
    chk(32'(got.size()), 32'h1);
    chk_e(0, 3'h1, 3'h3, 1'b0);
    apb(1'b1, OFS_MODE + 12'h008, 32'h3D);
    // weight 13 on the source adds two idle cycles after the frame
    apb(1'b1, OFS_MODE + 12'h004, 32'h35);
    put_frame(6'h01, 8'h00, 2'h0, 1'b0, 1'b0);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (in_ready !== 1'b1);
    chk(32'(n), 32'h5);
    apb(1'b1, OFS_MODE + 12'h004, 32'h3D);
    $display("test forwarding disable done");
  endtask : t_fwd_dis

  task automatic t_cong();
    int d0;
    // keep the first copy queued so the shared memory account stays full
    drain <= 1'b0;
    for (int r = 0; r < 4; r++) apb(1'b1, OFS_THR + 12'(4 * (r * 4 + 3)), 32'h3);
    apb(1'b1, OFS_MODE, 32'h3F);
    put_frame(6'h01, 8'h00, 2'h0, 1'b0, 1'b0);
    wait_idle();
    chk(32'(got.size()), 32'h1);
    d0 = ndisc;
    put_frame(6'h01, 8'h00, 2'h0, 1'b0, 1'b0);
    wait_idle();
    chk(32'(got.size()), 32'h0);
    chk(32'(ndisc - d0), 32'h1);
    apb(1'b1, OFS_MODE, 32'h3D);
    put_frame(6'h01, 8'h00, 2'h1, 1'b0, 1'b1);
    wait_idle();
    chk(32'(ndisc - d0), 32'h2);
    // mirror kept after a discard, then itself discarded for lack of room
    apb(1'b1, OFS_MIRROR, 32'h1);
    put_frame(6'h01, 8'h00, 2'h1, 1'b0, 1'b1);
    wait_idle();
    chk(32'(ndisc - d0), 32'h4);
    apb(1'b1, OFS_MIRROR, 32'h0);
    put_frame(6'h01, 8'h00, 2'h0, 1'b0, 1'b0);
    nblk = 0;
    repeat (8) @(posedge pclk);
    chk(32'(nblk > 4), 32'h1);
    chk(32'(got.size()), 32'h0);
    drain <= 1'b1;
    wait_idle();
    chk(32'(got.size()), 32'h1);
    chk(32'(ndisc - d0), 32'h4);
    for (int r = 0; r < 4; r++) apb(1'b1, OFS_THR + 12'(4 * (r * 4 + 3)), 32'h1740);
    $display("test congestion done");
  endtask : t_cong

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_dest();
    t_cpu_queue_mask();
    t_indirect();
    t_fwd_dis();
    t_cong();
    end_sim();
  end

  // whole run is a few hundred cycles
  initial begin
    #100000;
    mismatches = mismatches + 1;
    end_sim();
  end
endmodule : test_forwarder_congestion_acct
`default_nettype wire

//--- logic/fca_forwarder.sv
// Summary of operation
// - each destination set bit yields a switched copy to that front port
// - cpu queue, mirror and learn-all copies translate through the copy table
// - every selected cpu extraction queue of eight gets its own copy
// - a cpu queue entry maps to an internal cpu port or a front port
// - cpu queue egress class: ingress class, fixed class, or super priority
// - three mirror probes, each with its own egress port and class
// - learn-all copy goes to one stacking link or both
// - copy table has 12 entries covering all indirect destinations
// - separate setting names the extra learn-all egress port
// - disabled cpu queues receive no copies
// - global setting decides if discarded copies still get mirrored
// - per-port mode holds forwarding enable, speed weight and drop mode
// - congested copy: discard if drop-mode, else hold frame at queue head
// - analyzer flag lets a frame drop despite flow-control port
// - ingress class and drop precedence 0-3 feed congestion accounting
// - counters are charged when a reference is added to an egress queue
// - four resources: ingress/egress 176-byte words and ingress/egress references
// - 5,952 memory words and 5,952 frame references in total
// - sheet accounts: port-class, port, class, shared, in that order
// - later accounts are consumed only after earlier reservations are used up
// - admit if account not full, then charge the full amount
// - account at or above threshold is closed; zero reservation closes at once
// - drop-mode when ingress or egress port is drop port or analyzer says so
// - allowed when (ingress or egress memory) and (ingress or egress refs) allow
`timescale 1ns/1ns
`default_nettype none
module fca_forwarder
  import fca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire fca_frame_type in_frame,
  output logic in_ready,
  input wire fca_rel_type rel,
  output fca_enq_type enq,
  output logic disc_pulse,
  output logic blocked
);

  fca_regs_type s_ff;
  fca_regs_type nxt_s;
  fca_dec_type dec;
  logic [4:0] cur_b;
  logic [3:0] cur_ent;
  logic [PW-1:0] cur_port;
  logic [2:0] cur_qos;
  logic cur_super;
  logic pending;
  logic fwd_ok;
  logic dropm;
  logic allow;
  logic chg;
  logic [NRES-1:0] ok;
  logic [PW-1:0] rp;
  logic [2:0] rq;
  logic [CW-1:0] amt;
  logic [CW-1:0] old;
  logic [CW-1:0] nw;
  logic [CW-1:0] sh_lim;

  function automatic fca_dec_type decode(input logic [11:0] a);
    fca_dec_type d;
    d.kind = RK_NONE;
    d.idx = a[5:2];
    if (a < OFS_MODE + 12'(4 * NPORT)) d.kind = RK_MODE;
    else if (a >= OFS_COPY && a < OFS_COPY + 12'(4 * NCOPY)) begin
      d.kind = RK_COPY;
      d.idx = 4'((a - OFS_COPY) >> 2);
    end
    else if (a == OFS_LRN) d.kind = RK_LRN;
    else if (a == OFS_CPUDIS) d.kind = RK_CPUDIS;
    else if (a == OFS_MIRROR) d.kind = RK_MIRROR;
    else if (a == OFS_COLOR) d.kind = RK_COLOR;
    else if (a >= OFS_THR && a < OFS_THR + 12'(4 * NRES * NLVL)) d.kind = RK_THR;
    else if (a >= OFS_SHUSE && a < OFS_SHUSE + 12'(4 * NRES)) d.kind = RK_SHUSE;
    else if (a == OFS_DISC) d.kind = RK_DISC;
    else if (a == OFS_STAT) d.kind = RK_STAT;
    if (a[1:0] != 2'b00) d.kind = RK_NONE;
    return d;
  endfunction : decode

  function automatic logic [CW-1:0] over_th(input logic [CW-1:0] x, input logic [CW-1:0] th);
    return (x > th) ? x - th : '0;
  endfunction : over_th

  function automatic logic [CW-1:0] sub_sat(input logic [CW-1:0] x, input logic [CW-1:0] y);
    return (x > y) ? x - y : '0;
  endfunction : sub_sat

  // part of an update that runs past the threshold moves on to the next account
  function automatic logic [CW-1:0] spill(input logic [CW-1:0] o, input logic [CW-1:0] n,
                                          input logic [CW-1:0] th, input logic add);
    return add ? over_th(n, th) - over_th(o, th) : over_th(o, th) - over_th(n, th);
  endfunction : spill

  function automatic logic [4:0] lowest(input logic [NPEND-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NPEND - 1; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction : lowest

  always_comb begin
    nxt_s = s_ff;
    dec = decode(paddr);
    cur_b = lowest(s_ff.pend);
    pending = |s_ff.pend;
    chg = 1'b0;
    rp = '0;
    rq = '0;
    amt = '0;
    old = '0;
    nw = '0;
    sh_lim = '0;
    nxt_s.enq.valid = 1'b0;
    nxt_s.disc = 1'b0;
    nxt_s.blocked = 1'b0;

    // register bus: answer in the first access cycle, data staged during setup
    nxt_s.pready = psel & ~penable;
    nxt_s.pslverr = 1'b0;
    if (psel & ~penable) begin
      nxt_s.pslverr = (dec.kind == RK_NONE);
      nxt_s.prdata = '0;
      unique case (dec.kind)
        RK_MODE: nxt_s.prdata = 32'(s_ff.mode[dec.idx[2:0]]);
        RK_COPY: nxt_s.prdata = 32'(s_ff.cpy[dec.idx]);
        RK_LRN: nxt_s.prdata = 32'(s_ff.lrn);
        RK_CPUDIS: nxt_s.prdata = 32'(s_ff.cpu_dis);
        RK_MIRROR: nxt_s.prdata = 32'(s_ff.mir_disc);
        RK_COLOR: nxt_s.prdata = 32'(s_ff.color);
        RK_THR: nxt_s.prdata = 32'(s_ff.thr[dec.idx[3:2]][dec.idx[1:0]]);
        RK_SHUSE: nxt_s.prdata = 32'(s_ff.sh[dec.idx[1:0]]);
        RK_DISC: nxt_s.prdata = s_ff.disc_cnt;
        RK_STAT: nxt_s.prdata = 32'({s_ff.blocked, s_ff.st});
        RK_NONE: nxt_s.prdata = '0;
        default: nxt_s.prdata = '0;
      endcase
    end
    if (psel & penable & s_ff.pready & pwrite) begin
      unique case (dec.kind)
        RK_MODE: nxt_s.mode[dec.idx[2:0]] = fca_mode_type'(pwdata[5:0]);
        RK_COPY: nxt_s.cpy[dec.idx] = fca_copy_type'(pwdata[7:0]);
        RK_LRN: nxt_s.lrn = fca_lrn_type'(pwdata[3:0]);
        RK_CPUDIS: nxt_s.cpu_dis = pwdata[NCPUQ-1:0];
        RK_MIRROR: nxt_s.mir_disc = pwdata[0];
        RK_COLOR: nxt_s.color = pwdata[CW-1:0];
        RK_THR: nxt_s.thr[dec.idx[3:2]][dec.idx[1:0]] = pwdata[CW-1:0];
        default: nxt_s.disc_cnt = s_ff.disc_cnt;
      endcase
    end

    // resolve the copy for the lowest pending destination
    cur_ent = 4'(CPY_LRN);
    if (cur_b >= 5'(NFRONT) && cur_b < 5'(PB_MIR)) cur_ent = 4'(cur_b - 5'(NFRONT));
    else if (cur_b == 5'(PB_MIR)) cur_ent = 4'(NCPUQ - 1) + 4'(s_ff.fr.probe);
    cur_port = s_ff.cpy[cur_ent].port;
    cur_qos = s_ff.fr.qos;
    cur_super = 1'b0;
    if (cur_b < 5'(NFRONT)) cur_port = cur_b[PW-1:0];
    else begin
      if (s_ff.cpy[cur_ent].qmode != QM_INGRESS) cur_qos = s_ff.cpy[cur_ent].qos;
      cur_super = (s_ff.cpy[cur_ent].qmode == QM_SUPER);
      if (cur_b == 5'(PB_LRNX)) cur_port = s_ff.lrn.port;
    end
    fwd_ok = s_ff.mode[s_ff.fr.src].fwd_en & s_ff.mode[cur_port].fwd_en;
    dropm = s_ff.mode[s_ff.fr.src].drop | s_ff.mode[cur_port].drop | s_ff.fr.drop_ok;

    // admission: a resource is open while any account of its chain is still open
    for (int r = 0; r < NRES; r++) begin
      rp = r[0] ? cur_port : s_ff.fr.src;
      rq = r[0] ? cur_qos : s_ff.fr.qos;
      // yellower frames see less of the shared pool
      sh_lim = sub_sat(s_ff.thr[r][3], CW'(s_ff.fr.dp * s_ff.color));
      ok[r] = (s_ff.pq[r][rp][rq] < s_ff.thr[r][0]) | (s_ff.pp[r][rp] < s_ff.thr[r][1]) |
              (s_ff.pc[r][rq] < s_ff.thr[r][2]) | (s_ff.sh[r] < sh_lim);
    end
    allow = (ok[0] | ok[1]) & (ok[2] | ok[3]);

    unique case (s_ff.st)
      ST_IDLE: begin
        if (in_valid & s_ff.in_ready) begin
          nxt_s.in_ready = 1'b0;
          nxt_s.fr = in_frame;
          nxt_s.any_disc = 1'b0;
          nxt_s.pend = '0;
          nxt_s.pend[NFRONT-1:0] = in_frame.dest;
          nxt_s.pend[PB_MIR-1:NFRONT] = in_frame.cpu_queue_mask & ~s_ff.cpu_dis;
          nxt_s.pend[PB_MIR] = (in_frame.probe != 2'b00);
          nxt_s.pend[PB_LRN] = in_frame.learn_all;
          nxt_s.pend[PB_LRNX] = in_frame.learn_all & s_ff.lrn.both;
          nxt_s.st = ST_WORK;
        end
      end
      ST_WORK: begin
        if (!pending) begin
          nxt_s.gap = URG_MAX - s_ff.mode[s_ff.fr.src].urg;
          nxt_s.st = (nxt_s.gap == 4'h0) ? ST_IDLE : ST_GAP;
          nxt_s.in_ready = (nxt_s.gap == 4'h0);
        end
        else if (!fwd_ok) nxt_s.pend[cur_b] = 1'b0;
        else if (allow) begin
          nxt_s.pend[cur_b] = 1'b0;
          nxt_s.enq = '{valid: 1'b1, port: cur_port, qos: cur_qos, super_prio: cur_super,
                        src: s_ff.fr.src, words: s_ff.fr.words};
          chg = 1'b1;
        end
        else if (dropm) begin
          nxt_s.pend[cur_b] = 1'b0;
          nxt_s.disc = 1'b1;
          nxt_s.any_disc = 1'b1;
          nxt_s.disc_cnt = s_ff.disc_cnt + 32'h00000001;
          if (!s_ff.mir_disc) nxt_s.pend[PB_MIR] = 1'b0;
        end
        // flow control: the frame stays put and the port is stalled until accounts reopen
        else nxt_s.blocked = 1'b1;
      end
      ST_GAP: begin
        nxt_s.gap = s_ff.gap - 4'h1;
        if (s_ff.gap == 4'h1) begin
          nxt_s.st = ST_IDLE;
          nxt_s.in_ready = 1'b1;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
        nxt_s.in_ready = 1'b1;
      end
    endcase

    // op 0 releases, op 1 charges; a release in the same cycle is applied first
    for (int op = 0; op < 2; op++) begin
      if (op == 0 ? rel.valid : chg) begin
        for (int r = 0; r < NRES; r++) begin
          rp = r[0] ? (op == 1 ? cur_port : rel.egr) : (op == 1 ? s_ff.fr.src : rel.src);
          rq = r[0] ? (op == 1 ? cur_qos : rel.eqos) : (op == 1 ? s_ff.fr.qos : rel.iqos);
          amt = r[1] ? 14'h0001 : CW'(op == 1 ? s_ff.fr.words : rel.words);
          old = nxt_s.pq[r][rp][rq];
          nw = (op == 1) ? old + amt : sub_sat(old, amt);
          nxt_s.pq[r][rp][rq] = nw;
          amt = spill(old, nw, s_ff.thr[r][0], op == 1);
          old = nxt_s.pp[r][rp];
          nw = (op == 1) ? old + amt : sub_sat(old, amt);
          nxt_s.pp[r][rp] = nw;
          amt = spill(old, nw, s_ff.thr[r][1], op == 1);
          old = nxt_s.pc[r][rq];
          nw = (op == 1) ? old + amt : sub_sat(old, amt);
          nxt_s.pc[r][rq] = nw;
          amt = spill(old, nw, s_ff.thr[r][2], op == 1);
          // shared pool never passes the total of the resource
          nw = (op == 1) ? nxt_s.sh[r] + amt : sub_sat(nxt_s.sh[r], amt);
          nxt_s.sh[r] = (nw > TOTAL_WORDS) ? TOTAL_WORDS : nw;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_ff <= fca_reset_state();
    else s_ff <= nxt_s;
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign in_ready = s_ff.in_ready;
  assign enq = s_ff.enq;
  assign disc_pulse = s_ff.disc;
  assign blocked = s_ff.blocked;

  // helper state for the checks below only
  logic [PW-1:0] h_port_ff;
  logic [2:0] h_qos_ff;
  logic [CW-1:0] h_cnt_ff;
  logic [4:0] h_b_ff;
  logic [NCPUQ-1:0] h_cpu_queue_mask_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_port_ff <= '0;
      h_qos_ff <= '0;
      h_cnt_ff <= '0;
      h_b_ff <= '0;
      h_cpu_queue_mask_ff <= '0;
    end
    else begin
      h_port_ff <= cur_port;
      h_qos_ff <= cur_qos;
      h_cnt_ff <= s_ff.pq[3][cur_port][cur_qos];
      h_b_ff <= cur_b;
      h_cpu_queue_mask_ff <= in_frame.cpu_queue_mask;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_front_copy;
    (s_ff.st == ST_WORK && pending && cur_b < 5'(NFRONT) && fwd_ok && allow) |=>
      (enq.valid && enq.port == h_b_ff[PW-1:0]);
  endproperty
  a_front_copy: assert property (p_front_copy) else $error("front copy not sent to its port");

  property p_cpu_disable;
    (in_valid && in_ready) |=> (s_ff.pend[PB_MIR-1:NFRONT] == (h_cpu_queue_mask_ff & ~s_ff.cpu_dis));
  endproperty
  a_cpu_disable: assert property (p_cpu_disable) else $error("cpu queue pending set wrong");

  property p_hold;
    (s_ff.st == ST_WORK && pending && fwd_ok && !allow && !dropm) |=> ($stable(s_ff.pend) && blocked && !enq.valid);
  endproperty
  a_hold: assert property (p_hold) else $error("flow control frame not held");

  property p_drop;
    (s_ff.st == ST_WORK && pending && fwd_ok && !allow && dropm) |=> (disc_pulse && !enq.valid);
  endproperty
  a_drop: assert property (p_drop) else $error("drop mode copy not discarded");

  property p_charge;
    (s_ff.st == ST_WORK && pending && fwd_ok && allow && !rel.valid) |=>
      (s_ff.pq[3][h_port_ff][h_qos_ff] == h_cnt_ff + 14'h0001);
  endproperty
  a_charge: assert property (p_charge) else $error("egress reference not charged");

  property p_allow;
    enq.valid |-> $past(allow) && $past(s_ff.st == ST_WORK);
  endproperty
  a_allow: assert property (p_allow) else $error("copy enqueued without admission");

  property p_mirror;
    (s_ff.any_disc && !s_ff.mir_disc && s_ff.st == ST_WORK) |-> !s_ff.pend[PB_MIR];
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror kept after discard");

  property p_gap;
    (s_ff.st == ST_GAP) |-> (!in_ready ##1 (s_ff.st == ST_GAP || (s_ff.st == ST_IDLE && in_ready)));
  endproperty
  a_gap: assert property (p_gap) else $error("ingress accepted during weight gap");

  property p_disc_count;
    disc_pulse |-> (s_ff.disc_cnt == $past(s_ff.disc_cnt) + 32'h00000001);
  endproperty
  a_disc_count: assert property (p_disc_count) else $error("discard not counted");

  property p_front_plain;
    (enq.valid && h_b_ff < 5'(NFRONT)) |-> (!enq.super_prio && enq.qos == $past(s_ff.fr.qos));
  endproperty
  a_front_plain: assert property (p_front_plain) else $error("front copy class altered");

  property p_lrn_extra;
    (enq.valid && h_b_ff == 5'(PB_LRNX)) |-> (enq.port == s_ff.lrn.port);
  endproperty
  a_lrn_extra: assert property (p_lrn_extra) else $error("extra learn copy on wrong port");

  property p_work_busy;
    (s_ff.st != ST_IDLE) |-> !in_ready;
  endproperty
  a_work_busy: assert property (p_work_busy) else $error("ingress ready while frame in progress");

  c_super: cover property (enq.valid && enq.super_prio);
  c_block: cover property (blocked [*3] ##1 enq.valid);
  c_discard_then_mirror: cover property (disc_pulse ##[1:20] (enq.valid && s_ff.mir_disc));
  c_gap_end: cover property (s_ff.st == ST_GAP ##1 s_ff.st == ST_IDLE);
  c_lrn_both: cover property (enq.valid && h_b_ff == 5'(PB_LRNX));
endmodule : fca_forwarder
`default_nettype wire

//--- logic/fca_pkg.sv
package fca_pkg;
  localparam int NPORT = 8;
  localparam int NFRONT = 6;
  localparam int PW = 3;
  localparam int NQOS = 8;
  localparam int NCPUQ = 8;
  localparam int NCOPY = 12;
  localparam int CW = 14;
  localparam int WW = 6;
  localparam int NRES = 4;
  localparam int NLVL = 4;
  localparam int NPEND = NFRONT + NCPUQ + 3;
  localparam int PB_MIR = NFRONT + NCPUQ;
  localparam int PB_LRN = PB_MIR + 1;
  localparam int PB_LRNX = PB_MIR + 2;
  localparam int CPY_LRN = 11;
  localparam int WORD_BYTES = 176;
  localparam logic [CW-1:0] TOTAL_WORDS = 14'h1740;
  localparam logic [CW-1:0] TOTAL_REFS = 14'h1740;
  localparam logic [3:0] URG_MAX = 4'hF;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_COPY = 12'h040;
  localparam logic [11:0] OFS_LRN = 12'h080;
  localparam logic [11:0] OFS_CPUDIS = 12'h084;
  localparam logic [11:0] OFS_MIRROR = 12'h088;
  localparam logic [11:0] OFS_COLOR = 12'h08C;
  localparam logic [11:0] OFS_THR = 12'h0C0;
  localparam logic [11:0] OFS_SHUSE = 12'h100;
  localparam logic [11:0] OFS_DISC = 12'h110;
  localparam logic [11:0] OFS_STAT = 12'h114;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WORK = 2'b01, ST_GAP = 2'b10} fca_state_type;
  typedef enum logic [1:0] {QM_INGRESS = 2'b00, QM_FIXED = 2'b01, QM_SUPER = 2'b10} fca_qmode_type;
  typedef enum logic [3:0] {
    RK_NONE = 4'h0, RK_MODE = 4'h1, RK_COPY = 4'h2, RK_LRN = 4'h3, RK_CPUDIS = 4'h4, RK_MIRROR = 4'h5,
    RK_COLOR = 4'h6, RK_THR = 4'h7, RK_SHUSE = 4'h8, RK_DISC = 4'h9, RK_STAT = 4'hA
  } fca_rk_type;

  typedef struct packed {fca_rk_type kind; logic [3:0] idx;} fca_dec_type;
  typedef struct packed {logic [3:0] urg; logic drop; logic fwd_en;} fca_mode_type;
  typedef struct packed {fca_qmode_type qmode; logic [2:0] qos; logic [PW-1:0] port;} fca_copy_type;
  typedef struct packed {logic both; logic [PW-1:0] port;} fca_lrn_type;
  typedef struct packed {
    logic [PW-1:0] src;
    logic [NFRONT-1:0] dest;
    logic [NCPUQ-1:0] cpu_queue_mask;
    logic [1:0] probe;
    logic learn_all;
    logic [2:0] qos;
    logic [1:0] dp;
    logic drop_ok;
    logic [WW-1:0] words;
  } fca_frame_type;
  typedef struct packed {
    logic valid; logic [PW-1:0] port; logic [2:0] qos; logic super_prio; logic [PW-1:0] src; logic [WW-1:0] words;
  } fca_enq_type;
  typedef struct packed {
    logic valid; logic [PW-1:0] src; logic [PW-1:0] egr; logic [2:0] iqos; logic [2:0] eqos; logic [WW-1:0] words;
  } fca_rel_type;
  typedef struct packed {
    logic pready; logic [31:0] prdata; logic pslverr;
    fca_mode_type [NPORT-1:0] mode;
    fca_copy_type [NCOPY-1:0] cpy;
    fca_lrn_type lrn;
    logic [NCPUQ-1:0] cpu_dis;
    logic mir_disc;
    logic [CW-1:0] color;
    logic [NRES-1:0][NLVL-1:0][CW-1:0] thr;
    logic [NRES-1:0][NPORT-1:0][NQOS-1:0][CW-1:0] pq;
    logic [NRES-1:0][NPORT-1:0][CW-1:0] pp;
    logic [NRES-1:0][NQOS-1:0][CW-1:0] pc;
    logic [NRES-1:0][CW-1:0] sh;
    fca_state_type st;
    fca_frame_type fr;
    logic [NPEND-1:0] pend;
    logic any_disc;
    logic [3:0] gap;
    logic in_ready;
    logic blocked;
    fca_enq_type enq;
    logic disc;
    logic [31:0] disc_cnt;
  } fca_regs_type;

  function automatic fca_regs_type fca_reset_state();
    fca_regs_type r;
    r = '0;
    for (int p = 0; p < NPORT; p++) begin
      r.mode[p].fwd_en = 1'b1;
      r.mode[p].urg = URG_MAX;
    end
    for (int k = 0; k < NRES; k++) begin
      r.thr[k][NLVL-1] = k[1] ? TOTAL_REFS : TOTAL_WORDS;
    end
    r.st = ST_IDLE;
    r.in_ready = 1'b1;
    return r;
  endfunction : fca_reset_state
endpackage : fca_pkg
